// ==== hw/cdfc_top.sv ====
// Six configurable 8-bit ports with measuring and generating channels
`timescale 1ns/1ns
`default_nettype none
module cdfc_top #(
    parameter int unsigned NUM_CH = cdfc_pkg::CDFC_NUM_CH,
    parameter int unsigned TICK_W = cdfc_pkg::CDFC_TICK_W,
    parameter int unsigned IRQ_GAP = cdfc_pkg::CDFC_IRQ_GAP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [47:0] port_pins_in,
    output logic [47:0] port_pins_out,
    output logic [47:0] port_pins_oe,
    input wire logic [1:0] nv_cfg_in,
    output logic [1:0] nv_cfg_out,
    output logic nv_cfg_wr,
    output logic pin_event
);
    import cdfc_pkg::*;

    localparam int unsigned P = CDFC_PORT_W;
    localparam int unsigned TICK_ACC_W = 8;

    logic [7:0] dir_ff [CDFC_NUM_SUB];
    logic [7:0] out_ff [CDFC_NUM_SUB];
    logic [47:0] pins_ff;
    logic [47:0] pins_q_ff;
    logic [47:0] chg_ff;
    cdfc_cfg_t cfg_ff;
    logic cfg_loaded_ff;
    logic [TICK_W-1:0] per_ff [NUM_CH];
    logic [TICK_W-1:0] ph1_ff [NUM_CH];
    logic [TICK_W-1:0] mcnt_ff [NUM_CH];
    logic [TICK_W-1:0] mph_ff [NUM_CH];
    logic [NUM_CH-1:0] marmed_ff;
    logic [TICK_W-1:0] gper_ff [NUM_CH];
    logic [TICK_W-1:0] gph1_ff [NUM_CH];
    logic [TICK_W-1:0] gcnt_ff [NUM_CH];
    logic [NUM_CH-1:0] gen_ff;
    logic [NUM_CH-1:0] glow_ff;
    logic [NUM_CH-1:0] gen_lvl_ff;
    logic [TICK_ACC_W-1:0] tick_acc_ff;
    logic tick_ff;
    logic [31:0] gap_ff;
    logic [31:0] nxt_prdata;
    logic wr_en;
    logic rd_en;
    logic [11:0] ofs;
    logic [7:0] meas_in;
    logic [7:0] meas_prev_ff;

    function automatic logic in_range(input logic [11:0] a,
            input logic [11:0] base, input int unsigned n);
        in_range = (a >= base) && (a < base + 12'(n * 4));
    endfunction

    function automatic int unsigned idx(input logic [11:0] a,
            input logic [11:0] base);
        idx = int'((a - base) >> 2);
    endfunction

    assign ofs = {paddr[11:2], 2'b00};
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign meas_in = pins_ff[7:0];

    // Zero-wait slave; unmapped offsets answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped(ofs);
            if (rd_en) begin
                prdata <= nxt_prdata;
            end
        end
    end

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == CDFC_OFS_CFG) || (a == CDFC_OFS_STATUS)
            || in_range(a, CDFC_OFS_DIR, CDFC_NUM_SUB)
            || in_range(a, CDFC_OFS_OUT, CDFC_NUM_SUB)
            || in_range(a, CDFC_OFS_IN, CDFC_NUM_SUB)
            || in_range(a, CDFC_OFS_CHG, CDFC_NUM_SUB)
            || in_range(a, CDFC_OFS_PER, NUM_CH)
            || in_range(a, CDFC_OFS_PH1, NUM_CH)
            || in_range(a, CDFC_OFS_GPER, NUM_CH)
            || in_range(a, CDFC_OFS_GPH1, NUM_CH)
            || in_range(a, CDFC_OFS_GCTL, NUM_CH);
    endfunction

    always_comb begin
        nxt_prdata = 32'h0;
        if (ofs == CDFC_OFS_CFG) begin
            nxt_prdata = {30'h0, cfg_ff};
        end else if (ofs == CDFC_OFS_STATUS) begin
            nxt_prdata = {23'h0, cfg_loaded_ff, gen_lvl_ff};
        end else if (in_range(ofs, CDFC_OFS_DIR, CDFC_NUM_SUB)) begin
            nxt_prdata = {24'h0, dir_ff[idx(ofs, CDFC_OFS_DIR)]};
        end else if (in_range(ofs, CDFC_OFS_OUT, CDFC_NUM_SUB)) begin
            nxt_prdata = {24'h0, out_ff[idx(ofs, CDFC_OFS_OUT)]};
        end else if (in_range(ofs, CDFC_OFS_IN, CDFC_NUM_SUB)) begin
            // Pin levels even for outputs, so driven data reads back
            nxt_prdata = {24'h0,
                pins_ff[idx(ofs, CDFC_OFS_IN)*P +: P]};
        end else if (in_range(ofs, CDFC_OFS_CHG, CDFC_NUM_SUB)) begin
            nxt_prdata = {24'h0, chg_ff[idx(ofs, CDFC_OFS_CHG)*P +: P]};
        end else if (in_range(ofs, CDFC_OFS_PER, NUM_CH)) begin
            nxt_prdata = 32'(per_ff[idx(ofs, CDFC_OFS_PER)]);
        end else if (in_range(ofs, CDFC_OFS_PH1, NUM_CH)) begin
            nxt_prdata = 32'(ph1_ff[idx(ofs, CDFC_OFS_PH1)]);
        end else if (in_range(ofs, CDFC_OFS_GPER, NUM_CH)) begin
            nxt_prdata = 32'(gper_ff[idx(ofs, CDFC_OFS_GPER)]);
        end else if (in_range(ofs, CDFC_OFS_GPH1, NUM_CH)) begin
            nxt_prdata = 32'(gph1_ff[idx(ofs, CDFC_OFS_GPH1)]);
        end else if (in_range(ofs, CDFC_OFS_GCTL, NUM_CH)) begin
            nxt_prdata = {30'h0, glow_ff[idx(ofs, CDFC_OFS_GCTL)],
                gen_ff[idx(ofs, CDFC_OFS_GCTL)]};
        end
    end

    // Configuration: strapped value taken one edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= CDFC_CFG_RST;
            cfg_loaded_ff <= 1'b0;
            nv_cfg_out <= CDFC_CFG_RST;
            nv_cfg_wr <= 1'b0;
        end else begin
            nv_cfg_wr <= 1'b0;
            if (!cfg_loaded_ff) begin
                cfg_ff <= nv_cfg_in;
                cfg_loaded_ff <= 1'b1;
            end else if (wr_en && ofs == CDFC_OFS_CFG) begin
                cfg_ff <= pwdata[1:0];
                if (pwdata[CDFC_CFG_SAVE_BIT]) begin
                    nv_cfg_out <= pwdata[1:0];
                    nv_cfg_wr <= 1'b1;
                end
            end
        end
    end

    // Per-port direction and data, reset to inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CDFC_NUM_SUB; i++) begin
                dir_ff[i] <= 8'h00;
                out_ff[i] <= 8'h00;
            end
        end else if (wr_en) begin
            for (int i = 0; i < CDFC_NUM_SUB; i++) begin
                if (ofs == CDFC_OFS_DIR + 12'(i * 4)) begin
                    dir_ff[i] <= pwdata[7:0];
                end
                if (ofs == CDFC_OFS_OUT + 12'(i * 4)) begin
                    out_ff[i] <= pwdata[7:0];
                end
            end
        end
    end

    // Pin drive; generator pins stay off until a channel is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_pins_out <= 48'h0;
            port_pins_oe <= 48'h0;
        end else begin
            for (int i = 0; i < CDFC_NUM_SUB; i++) begin
                port_pins_out[i*P +: P] <= out_ff[i];
                port_pins_oe[i*P +: P] <= dir_ff[i];
            end
            if (cfg_ff.meas_sel) begin
                port_pins_oe[7:0] <= 8'h00;
            end
            if (cfg_ff.gen_sel) begin
                port_pins_out[15:8] <= gen_lvl_ff;
                port_pins_oe[15:8] <= gen_ff;
            end
        end
    end

    // Pin capture and change detection; only the pin_event output is rate limited
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_ff <= 48'h0;
            pins_q_ff <= 48'h0;
            chg_ff <= 48'h0;
            gap_ff <= 32'h0;
            pin_event <= 1'b0;
        end else begin
            pins_ff <= port_pins_in;
            pins_q_ff <= pins_ff;
            pin_event <= 1'b0;
            if (gap_ff != 32'h0) begin
                gap_ff <= gap_ff - 32'h1;
            end
            for (int i = 0; i < CDFC_NUM_SUB; i++) begin
                // Set wins over a software clear in the same cycle
                if (wr_en && ofs == CDFC_OFS_CHG + 12'(i * 4)) begin
                    chg_ff[i*P +: P] <= (chg_ff[i*P +: P] & ~pwdata[7:0])
                        | ((pins_ff[i*P +: P] ^ pins_q_ff[i*P +: P])
                        & ~dir_ff[i]);
                end else begin
                    chg_ff[i*P +: P] <= chg_ff[i*P +: P]
                        | ((pins_ff[i*P +: P] ^ pins_q_ff[i*P +: P])
                        & ~dir_ff[i]);
                end
            end
            if (gap_ff == 32'h0 && |((pins_ff ^ pins_q_ff)
                    & ~{dir_ff[5], dir_ff[4], dir_ff[3], dir_ff[2],
                    dir_ff[1], dir_ff[0]})) begin
                pin_event <= 1'b1;
                gap_ff <= 32'(IRQ_GAP - 1);
            end
        end
    end

    // 66 MHz tick from 100 MHz by fractional accumulation (33 of 50)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_acc_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (tick_acc_ff + 8'd33 >= 8'd50) begin
            tick_acc_ff <= tick_acc_ff + 8'd33 - 8'd50;
            tick_ff <= 1'b1;
        end else begin
            tick_acc_ff <= tick_acc_ff + 8'd33;
            tick_ff <= 1'b0;
        end
    end

    // Measuring channels: rising to rising gives period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_prev_ff <= 8'h00;
            marmed_ff <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                mcnt_ff[c] <= '0;
                mph_ff[c] <= '0;
                per_ff[c] <= '0;
                ph1_ff[c] <= '0;
            end
        end else begin
            meas_prev_ff <= meas_in;
            for (int c = 0; c < NUM_CH; c++) begin
                if (!cfg_ff.meas_sel) begin
                    marmed_ff[c] <= 1'b0;
                end else if (meas_in[c] && !meas_prev_ff[c]) begin
                    if (marmed_ff[c]) begin
                        per_ff[c] <= mcnt_ff[c];
                        ph1_ff[c] <= mph_ff[c];
                    end
                    marmed_ff[c] <= 1'b1;
                    mcnt_ff[c] <= TICK_W'(tick_ff);
                    mph_ff[c] <= '0;
                end else begin
                    if (tick_ff && mcnt_ff[c] != '1) begin
                        mcnt_ff[c] <= mcnt_ff[c] + 1'b1;
                    end
                    if (!meas_in[c] && meas_prev_ff[c]) begin
                        mph_ff[c] <= mcnt_ff[c];
                    end
                end
            end
        end
    end

    // Generator settings written per channel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_ff <= '0;
            glow_ff <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                gper_ff[c] <= '0;
                gph1_ff[c] <= '0;
            end
        end else if (wr_en) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (ofs == CDFC_OFS_GPER + 12'(c * 4)) begin
                    gper_ff[c] <= TICK_W'(pwdata);
                end
                if (ofs == CDFC_OFS_GPH1 + 12'(c * 4)) begin
                    gph1_ff[c] <= TICK_W'(pwdata);
                end
                if (ofs == CDFC_OFS_GCTL + 12'(c * 4)) begin
                    gen_ff[c] <= pwdata[0];
                    glow_ff[c] <= pwdata[1];
                end
            end
        end
    end

    // Generator counters; period of N ticks counts 0..N-1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_lvl_ff <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                gcnt_ff[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (!gen_ff[c] || !cfg_ff.gen_sel) begin
                    gcnt_ff[c] <= '0;
                    gen_lvl_ff[c] <= glow_ff[c];
                end else begin
                    if (tick_ff) begin
                        if (gcnt_ff[c] + 1'b1 >= gper_ff[c]) begin
                            gcnt_ff[c] <= '0;
                        end else begin
                            gcnt_ff[c] <= gcnt_ff[c] + 1'b1;
                        end
                    end
                    // High during first phase unless start-low inverts
                    gen_lvl_ff[c] <= (gcnt_ff[c] < gph1_ff[c])
                        ^ glow_ff[c];
                end
            end
        end
    end

    chk_reset_inputs: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> port_pins_oe == 48'h0)
        else $error("ports not inputs after reset");
    chk_gen_hiz: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_ff.gen_sel && !gen_ff[0] |=> !port_pins_oe[8])
        else $error("generator pin driven while off");
    chk_pair_update: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_ff.meas_sel && marmed_ff[0] && meas_in[0] && !meas_prev_ff[0]
        |=> per_ff[0] == $past(mcnt_ff[0]) && ph1_ff[0] == $past(mph_ff[0]))
        else $error("result pair split");
    chk_event_gap: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_event |=> !pin_event [*2])
        else $error("events too close");
    // First edge after reset is a legal idle tick slot
    chk_tick_rate: assert property (
        @(posedge pclk) disable iff (!presetn)
        !tick_ff && $past(presetn) |=> tick_ff)
        else $error("tick missing");
    chk_read_back: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_en && ofs == CDFC_OFS_IN + 12'h00C
        |=> prdata[7:0] == $past(pins_ff[31:24]))
        else $error("pin read back wrong");
    chk_gen_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        gen_ff[0] && cfg_ff.gen_sel && $past(gen_ff[0])
        |=> gen_lvl_ff[0] == (($past(gcnt_ff[0]) < $past(gph1_ff[0]))
        ^ $past(glow_ff[0])))
        else $error("generator level wrong");
    chk_dir_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && ofs == CDFC_OFS_DIR + 12'h00C
        |=> dir_ff[3] == $past(pwdata[7:0]) ##0 $stable(dir_ff[2]))
        else $error("direction write wrong");
    cov_meas: cover property (@(posedge pclk) $changed(per_ff[0]));
    cov_gen: cover property (@(posedge pclk) $rose(gen_lvl_ff[0]));
    cov_event: cover property (@(posedge pclk) pin_event);
endmodule
`default_nettype wire

// ==== include/cdfc_pkg.sv ====
// Shared constants and types of the configurable port and timer block
package cdfc_pkg;
    localparam int unsigned CDFC_NUM_SUB = 6;
    localparam int unsigned CDFC_PORT_W = 8;
    localparam int unsigned CDFC_NUM_CH = 8;
    localparam int unsigned CDFC_TICK_W = 32;
    localparam int unsigned CDFC_CLK_HZ = 100000000;
    localparam int unsigned CDFC_TICK_HZ = 66000000;
    localparam int unsigned CDFC_IRQ_RATE_HZ = 10000;
    localparam int unsigned CDFC_IRQ_GAP_CYC = CDFC_CLK_HZ / CDFC_IRQ_RATE_HZ;
    // Register byte offsets
    localparam logic [11:0] CDFC_OFS_CFG = 12'h000;
    localparam logic [11:0] CDFC_OFS_STATUS = 12'h004;
    localparam logic [11:0] CDFC_OFS_DIR = 12'h010;
    localparam logic [11:0] CDFC_OFS_OUT = 12'h040;
    localparam logic [11:0] CDFC_OFS_IN = 12'h070;
    localparam logic [11:0] CDFC_OFS_CHG = 12'h0A0;
    localparam logic [11:0] CDFC_OFS_PER = 12'h100;
    localparam logic [11:0] CDFC_OFS_PH1 = 12'h140;
    localparam logic [11:0] CDFC_OFS_GPER = 12'h200;
    localparam logic [11:0] CDFC_OFS_GPH1 = 12'h240;
    localparam logic [11:0] CDFC_OFS_GCTL = 12'h280;
    localparam int unsigned CDFC_CFG_SAVE_BIT = 8;
    localparam logic [1:0] CDFC_CFG_RST = 2'h0;
    localparam logic [31:0] CDFC_BAD_DATA = 32'h0;
    typedef struct packed {
        logic meas_sel;
        logic gen_sel;
    } cdfc_cfg_t;
    typedef struct packed {
        logic [CDFC_TICK_W-1:0] period;
        logic [CDFC_TICK_W-1:0] first_phase_duration;
    } cdfc_pair_t;
endpackage

// ==== tb/cdfc_field_model.sv ====
// Field side model: pin resolution, test waves and config store
`timescale 1ns/1ns
`default_nettype none
module cdfc_field_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [47:0] field_lvl,
    input wire logic wave_en,
    input wire logic [47:0] pins_out,
    input wire logic [47:0] pins_oe,
    output logic [47:0] pins_in,
    input wire logic [1:0] nv_out,
    input wire logic nv_wr,
    output logic [1:0] nv_in
);
    int cnt_ff [2];
    // Wave c: period 50*(c+1) cycles, high for 25+5c cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff[0] <= 0;
            cnt_ff[1] <= 0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                cnt_ff[c] <= (cnt_ff[c] >= 50 * (c + 1) - 1) ? 0
                    : cnt_ff[c] + 1;
            end
        end
    end
    // Driven pins read back their own level, except pins 0 and 1 while wave_en is set
    always_comb begin
        for (int b = 0; b < 48; b++) begin
            pins_in[b] = pins_oe[b] ? pins_out[b] : field_lvl[b];
        end
        if (wave_en) begin
            pins_in[0] = cnt_ff[0] < 25;
            pins_in[1] = cnt_ff[1] < 30;
        end
    end
    // Store survives reset, like the board memory
    initial nv_in = 2'h3;
    always @(posedge pclk) begin
        if (nv_wr === 1'b1) begin
            nv_in <= nv_out;
        end
    end
endmodule
`default_nettype wire

// ==== tb/cdfc_top_tb.sv ====
// Self-checking bench for the port and timer block
`timescale 1ns/1ns
`default_nettype none
module cdfc_top_tb;
    import cdfc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, hi, lo;
    logic [47:0] pins_in, pins_out, pins_oe, field_lvl, exp_oe;
    logic [1:0] nv_in, nv_out;
    logic nv_wr, pin_event, wave_en, last_err;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int ev_cnt = 0;
    int base;

    cdfc_top #(.IRQ_GAP(20)) cdfc_top_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_pins_in(pins_in), .port_pins_out(pins_out),
        .port_pins_oe(pins_oe), .nv_cfg_in(nv_in), .nv_cfg_out(nv_out),
        .nv_cfg_wr(nv_wr), .pin_event(pin_event));
    cdfc_field_model cdfc_field_model_inst (.pclk(pclk), .presetn(presetn),
        .field_lvl(field_lvl), .wave_en(wave_en), .pins_out(pins_out),
        .pins_oe(pins_oe), .pins_in(pins_in), .nv_out(nv_out),
        .nv_wr(nv_wr), .nv_in(nv_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Hang guard, well above the roughly 1000 cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (pin_event === 1'b1) begin
            ev_cnt++;
        end
        if (cyc == 30000) begin
            failures++;
            final_report;
        end
    end

    task automatic final_report;
        begin
            $display("compared=%0d failures=%0d", n_compared, failures);
            if (failures == 0 && n_compared > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Tick counts may land one off from clock-rate jitter
    task automatic chk_rng(input logic [31:0] got, input int c);
        n_compared++;
        if ($isunknown(got) || got + 1 < c || got > c + 1) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, c);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // Ends when pready rises; if it never does, only the hang guard ends this wait
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            last_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        apb(a, 1'b1, wd, dummy);
    endtask

    // Length of one whole run of generator 0 at the given level
    task automatic gen_phase(input logic lvl, output logic [31:0] dur);
        int n;
        begin
            n = 0;
            dur = 0;
            while (pins_out[8] !== ~lvl && n < 500) begin
                @(posedge pclk);
                n++;
            end
            while (pins_out[8] !== lvl && n < 500) begin
                @(posedge pclk);
                n++;
            end
            while (pins_out[8] === lvl && n < 500) begin
                @(posedge pclk);
                dur++;
                n++;
            end
        end
    endtask

    initial begin
        {psel, penable, pwrite, last_err, wave_en} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        field_lvl = 48'h0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(pins_oe, 48'h0);
        apb(CDFC_OFS_CFG, 1'b0, 32'h0, d);
        chk(d[1:0], 2'h3);
        apb(CDFC_OFS_STATUS, 1'b0, 32'h0, d);
        chk(d[8], 1'b1);
        exp_oe = 48'h0;
        for (int s = 2; s < 6; s++) begin
            wr(CDFC_OFS_DIR + 12'(4 * s), 32'hFF);
            wr(CDFC_OFS_OUT + 12'(4 * s), 32'hA0 + s);
            exp_oe[8 * s +: 8] = 8'hFF;
            chk(pins_oe, exp_oe);
            // Pin and capture stages lag the data write
            repeat (2) @(posedge pclk);
            apb(CDFC_OFS_IN + 12'(4 * s), 1'b0, 32'h0, d);
            chk(d[7:0], 8'hA0 + s);
        end
        apb(12'hFFC, 1'b0, 32'h0, d);
        chk({last_err, d}, 33'h1_0000_0000);
        wr(12'hFFC, 32'hFF);
        wr(CDFC_OFS_DIR + 12'h00C, 32'h0);
        exp_oe[31:24] = 8'h00;
        // Let the release event and its quiet gap pass first
        repeat (25) @(posedge pclk);
        chk(pins_oe, exp_oe);
        wr(CDFC_OFS_CHG + 12'h00C, 32'hFF);
        base = ev_cnt;
        field_lvl[24] <= 1'b1;
        @(posedge pclk);
        field_lvl[25] <= 1'b1;
        repeat (15) @(posedge pclk);
        chk(ev_cnt - base, 1);
        apb(CDFC_OFS_IN + 12'h00C, 1'b0, 32'h0, d);
        chk(d[7:0], 8'h03);
        apb(CDFC_OFS_CHG + 12'h00C, 1'b0, 32'h0, d);
        chk(d[7:0], 8'h03);
        wr(CDFC_OFS_CHG + 12'h00C, 32'h3);
        apb(CDFC_OFS_CHG + 12'h00C, 1'b0, 32'h0, d);
        chk(d[7:0], 8'h00);
        wave_en <= 1'b1;
        repeat (400) @(posedge pclk);
        for (int c = 0; c < 2; c++) begin
            apb(CDFC_OFS_PER + 12'(4 * c), 1'b0, 32'h0, d);
            chk_rng(d, 33 * (c + 1));
            apb(CDFC_OFS_PH1 + 12'(4 * c), 1'b0, 32'h0, d);
            chk_rng(d, (25 + 5 * c) * 33 / 50);
        end
        chk(pins_oe[15:8], 8'h00);
        wr(CDFC_OFS_GPER, 32'd66);
        wr(CDFC_OFS_GPH1, 32'd20);
        wr(CDFC_OFS_GCTL, 32'h1);
        repeat (2) @(posedge pclk);
        chk(pins_oe[8], 1'b1);
        gen_phase(1'b1, hi);
        gen_phase(1'b0, lo);
        chk_rng(hi, 30);
        chk_rng(hi + lo, 100);
        gen_phase(1'b0, lo);
        apb(CDFC_OFS_STATUS, 1'b0, 32'h0, d);
        chk(d[0], 1'b1);
        wr(CDFC_OFS_GCTL, 32'h3);
        gen_phase(1'b0, lo);
        gen_phase(1'b0, lo);
        chk_rng(lo, 30);
        wr(CDFC_OFS_CFG, 32'h100);
        repeat (3) @(posedge pclk);
        chk(nv_in, 2'h0);
        apb(CDFC_OFS_CFG, 1'b0, 32'h0, d);
        chk(d[1:0], 2'h0);
        // Store 3, run with 0, then restart: the stored value returns
        wr(CDFC_OFS_CFG, 32'h103);
        wr(CDFC_OFS_CFG, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(pins_oe, 48'h0);
        apb(CDFC_OFS_CFG, 1'b0, 32'h0, d);
        chk(d[1:0], 2'h3);
        final_report;
    end
endmodule
`default_nettype wire
